//--- verilog/line_if_pkg.sv
// shared constants, types and register map for the line-interface register set
package line_if_pkg;

   // register offsets on the parallel control port
   localparam logic [7:0] OFF_INFO_RT = 8'h11;
   localparam logic [7:0] OFF_STATUS_ONE = 8'h16;
   localparam logic [7:0] OFF_MASK_ONE = 8'h17;
   localparam logic [7:0] OFF_CTRL_TWO = 8'h79;
   localparam logic [7:0] OFF_CTRL_CLK_CMI = 8'h7b;
   localparam logic [7:0] OFF_SIG_ENABLE = 8'h40;

   localparam logic [7:0] RESET_BYTE = 8'h00;

   // line_ctrl_clock_cmi fields
   localparam int CMI_EN_BIT = 7;
   localparam int CMI_INV_BIT = 6;
   localparam int PRESCALE_HI_BIT = 5;
   localparam int PRESCALE_LO_BIT = 4;
   // line_ctrl_two fields
   localparam int E1_MODE_BIT = 7;
   localparam int JITTER_SRC_BIT = 3;

   // status / mask bit positions
   localparam int ST_TX_CLK_LOST = 0;
   localparam int ST_TX_OPEN = 1;
   localparam int ST_CUR_LIMIT = 2;
   localparam int ST_CARRIER_LOST = 3;
   localparam int ST_JITTER_TRIP = 4;
   localparam int ST_SIG_CHANGE = 5;
   localparam int ST_TIMER = 6;
   localparam int ST_BELOW_THRESH = 7;
   // condition sources interrupt on both edges, the rest on occurrence
   localparam logic [7:0] CONDITION_MASK = 8'h8f;

   // master clock bases in kHz
   localparam logic [14:0] MCLK_T1_BASE_KHZ = 15'h0608;
   localparam logic [14:0] MCLK_E1_BASE_KHZ = 15'h0800;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CHAN_TIME_T1_NS = 5180;
   localparam int CHAN_TIME_E1_NS = 3906;
   localparam int CHAN_CYC_T1 = (CHAN_TIME_T1_NS / CLK_PERIOD_NS < 1) ? 1 :
      CHAN_TIME_T1_NS / CLK_PERIOD_NS;
   localparam int CHAN_CYC_E1 = (CHAN_TIME_E1_NS / CLK_PERIOD_NS < 1) ? 1 :
      CHAN_TIME_E1_NS / CLK_PERIOD_NS;
   localparam int THRESH_TIME_MS = 50;

   // pattern synchroniser
   localparam logic [5:0] SYNC_MATCH_BITS = 6'h20;
   localparam logic [6:0] ERR_WINDOW_BITS = 7'h40;
   localparam logic [2:0] ERR_LIMIT = 3'h6;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic tx_open;
      logic cur_limit;
      logic carrier_lost;
      logic below_thresh;
      logic code_seen;
      logic [3:0] level;
   } line_sense_t;

   typedef enum logic [1:0] {
      PS_HUNT = 2'b01,
      PS_LOCKED = 2'b10
   } psync_state_t;

endpackage

//--- verilog/pattern_sync.sv
// test-pattern synchroniser: locks on consecutive matches, drops on error density
`timescale 1ns/10ps
`default_nettype none
module pattern_sync
   import line_if_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // received pattern bits
   input wire logic bit_tick,
   input wire logic bit_err,
   // state
   output logic pattern_sync_live
);
   psync_state_t state_ff, nxt_state;
   logic [5:0] match_ff, nxt_match;
   logic [6:0] win_ff, nxt_win;
   logic [2:0] err_ff, nxt_err;
   wire logic last_match = (match_ff == SYNC_MATCH_BITS - 6'h01);
   wire logic last_bit = (win_ff == ERR_WINDOW_BITS - 7'h01);
   wire logic err_full = (err_ff == ERR_LIMIT - 3'h1);

   always_comb begin
      nxt_state = state_ff;
      nxt_match = match_ff;
      nxt_win = win_ff;
      nxt_err = err_ff;
      case (state_ff)
         PS_HUNT: begin
            if (bit_tick) begin
               nxt_match = bit_err ? 6'h00 : match_ff + 6'h01;
               if (!bit_err && last_match) begin
                  nxt_state = PS_LOCKED;
                  nxt_match = 6'h00;
                  nxt_win = 7'h00;
                  nxt_err = 3'h0;
               end
            end
         end
         PS_LOCKED: begin
            if (bit_tick) begin
               nxt_win = last_bit ? 7'h00 : win_ff + 7'h01;
               nxt_err = last_bit ? 3'h0 : err_ff + {2'b00, bit_err};
               if (bit_err && err_full) begin
                  nxt_state = PS_HUNT;
                  nxt_win = 7'h00;
                  nxt_err = 3'h0;
               end
            end
         end
         default: nxt_state = PS_HUNT;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_ff <= PS_HUNT;
         match_ff <= 6'h00;
         win_ff <= 7'h00;
         err_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         match_ff <= nxt_match;
         win_ff <= nxt_win;
         err_ff <= nxt_err;
      end
   end

   assign pattern_sync_live = (state_ff == PS_LOCKED);
endmodule
`default_nettype wire

//--- verilog/line_interface_status_irq.sv
// line-interface control, real-time info, latched status and interrupt mask registers
`timescale 1ns/10ps
`default_nettype none
module line_interface_status_irq
   import line_if_pkg::*;
#(
   parameter int unsigned TIMER_T1_SEC_BITS = 1544000,
   parameter int unsigned TIMER_T1_FAST_BITS = 64848,
   parameter int unsigned TIMER_E1_SEC_BITS = 2048000,
   parameter int unsigned TIMER_E1_FAST_BITS = 128000,
   parameter int unsigned THRESH_CYCLES = THRESH_TIME_MS * 1000000 / CLK_PERIOD_NS
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // parallel control port
   input wire cpu_req_t cpu_req,
   output logic [7:0] cpu_rdata,
   output logic cpu_rvalid,
   // analog front-end sense pins
   input wire line_sense_t sense_pins,
   input wire logic tx_clock_in,
   input wire logic jitter_fifo_near,
   // framer-side inputs
   input wire logic rx_bit_tick,
   input wire logic pattern_bit_err,
   input wire logic [7:0] sig_state,
   input wire logic count_interval_sel,
   // line coding
   input wire logic tx_cmi_data,
   output logic tx_line_pos,
   input wire logic rx_line_pos,
   output logic rx_cmi_data,
   output logic coded_mark_enable,
   // clocking controls
   output logic [14:0] mclk_expect_khz,
   output logic jitter_atten_clock_pll,
   output logic e1_mode,
   // interrupt
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [14:0] mclk_khz(input logic [1:0] pre, input logic base_e1);
      mclk_khz = (base_e1 ? MCLK_E1_BASE_KHZ : MCLK_T1_BASE_KHZ) << pre;
   endfunction

   function automatic logic hit(input logic [7:0] off);
      hit = (cpu_req.addr == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two stages before any logic
   line_sense_t sense_m_ff, sense_ff;
   logic [2:0] txc_ff;
   logic rxl_m_ff, rxl_ff;
   logic jf_m_ff, jf_ff, jf_d_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sense_m_ff <= '0;
         sense_ff <= '0;
         txc_ff <= 3'h0;
         rxl_m_ff <= 1'b0;
         rxl_ff <= 1'b0;
         jf_m_ff <= 1'b0;
         jf_ff <= 1'b0;
         jf_d_ff <= 1'b0;
      end else begin
         sense_m_ff <= sense_pins;
         sense_ff <= sense_m_ff;
         txc_ff <= {txc_ff[1:0], tx_clock_in};
         rxl_m_ff <= rx_line_pos;
         rxl_ff <= rxl_m_ff;
         jf_m_ff <= jitter_fifo_near;
         jf_ff <= jf_m_ff;
         jf_d_ff <= jf_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] ctrl_cmi_ff, ctrl_two_ff, mask_ff, sig_en_ff;
   wire logic wr_cmi = cpu_req.wr && hit(OFF_CTRL_CLK_CMI);
   wire logic wr_two = cpu_req.wr && hit(OFF_CTRL_TWO);
   wire logic wr_mask = cpu_req.wr && hit(OFF_MASK_ONE);
   wire logic wr_sig = cpu_req.wr && hit(OFF_SIG_ENABLE);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_cmi_ff <= RESET_BYTE;
         ctrl_two_ff <= RESET_BYTE;
         mask_ff <= RESET_BYTE;
         sig_en_ff <= RESET_BYTE;
      end else begin
         if (wr_cmi) ctrl_cmi_ff <= cpu_req.wdata;
         if (wr_two) ctrl_two_ff <= cpu_req.wdata;
         if (wr_mask) mask_ff <= cpu_req.wdata;
         if (wr_sig) sig_en_ff <= cpu_req.wdata;
      end
   end

   wire logic [1:0] clk_prescale = {ctrl_cmi_ff[PRESCALE_HI_BIT], ctrl_cmi_ff[PRESCALE_LO_BIT]};
   wire logic jitter_clock_source_sel = ctrl_two_ff[JITTER_SRC_BIT];
   wire logic coded_mark_invert = ctrl_cmi_ff[CMI_INV_BIT];
   wire logic e1_sel = ctrl_two_ff[E1_MODE_BIT];
   // e1 or the pll source selects the 2.048 MHz base, in t1 mode as well
   wire logic base_e1 = e1_sel || jitter_clock_source_sel;

   ////////////////////////////////////////////////////////////////////////////
   // clocking and line coding outputs
   logic [14:0] mclk_ff;
   logic tx_pos_ff, rx_cmi_ff;
   wire logic cmi_flip = ctrl_cmi_ff[CMI_EN_BIT] && coded_mark_invert;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mclk_ff <= 15'h0000;
         tx_pos_ff <= 1'b0;
         rx_cmi_ff <= 1'b0;
      end else begin
         mclk_ff <= mclk_khz(clk_prescale, base_e1);
         tx_pos_ff <= tx_cmi_data ^ cmi_flip;
         rx_cmi_ff <= rxl_ff ^ cmi_flip;
      end
   end

   assign mclk_expect_khz = mclk_ff;
   assign jitter_atten_clock_pll = jitter_clock_source_sel;
   assign coded_mark_enable = ctrl_cmi_ff[CMI_EN_BIT];
   assign e1_mode = e1_sel;
   assign tx_line_pos = tx_pos_ff;
   assign rx_cmi_data = rx_cmi_ff;

   ////////////////////////////////////////////////////////////////////////////
   // transmit clock watchdog, one channel time without an edge
   logic [6:0] txc_cnt_ff;
   logic tx_clock_lost_ff;
   wire logic txc_edge = txc_ff[2] ^ txc_ff[1];
   wire logic [6:0] chan_limit = e1_sel ? 7'(CHAN_CYC_E1) : 7'(CHAN_CYC_T1);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txc_cnt_ff <= 7'h00;
         tx_clock_lost_ff <= 1'b0;
      end else if (txc_edge) begin
         txc_cnt_ff <= 7'h00;
         tx_clock_lost_ff <= 1'b0;
      end else if (txc_cnt_ff >= chan_limit - 7'h01) begin
         tx_clock_lost_ff <= 1'b1;
      end else begin
         txc_cnt_ff <= txc_cnt_ff + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input-under-threshold qualifier
   logic [22:0] thr_cnt_ff;
   logic below_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         thr_cnt_ff <= 23'h000000;
         below_ff <= 1'b0;
      end else if (!sense_ff.below_thresh) begin
         thr_cnt_ff <= 23'h000000;
         below_ff <= 1'b0;
      end else if (thr_cnt_ff >= 23'(THRESH_CYCLES - 1)) begin
         below_ff <= 1'b1;
      end else begin
         thr_cnt_ff <= thr_cnt_ff + 23'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error-counter update timer on receive bit ticks
   logic [20:0] tmr_cnt_ff;
   logic timer_evt_ff;
   wire logic [20:0] tmr_limit = e1_sel ?
      (count_interval_sel ? 21'(TIMER_E1_FAST_BITS) : 21'(TIMER_E1_SEC_BITS)) :
      (count_interval_sel ? 21'(TIMER_T1_FAST_BITS) : 21'(TIMER_T1_SEC_BITS));
   wire logic tmr_wrap = rx_bit_tick && (tmr_cnt_ff >= tmr_limit - 21'h000001);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tmr_cnt_ff <= 21'h000000;
         timer_evt_ff <= 1'b0;
      end else begin
         timer_evt_ff <= tmr_wrap;
         if (tmr_wrap) tmr_cnt_ff <= 21'h000000;
         else if (rx_bit_tick) tmr_cnt_ff <= tmr_cnt_ff + 21'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // signalling change detect, only on enabled channels
   logic [7:0] sig_prev_ff;
   logic sig_evt_ff;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sig_prev_ff <= 8'h00;
         sig_evt_ff <= 1'b0;
      end else begin
         sig_prev_ff <= sig_state;
         sig_evt_ff <= |((sig_state ^ sig_prev_ff) & sig_en_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pattern synchroniser
   logic pattern_sync_live;
   pattern_sync u_psync (
      .sys_clk(sys_clk),
      .rst(rst),
      .bit_tick(rx_bit_tick),
      .bit_err(pattern_bit_err),
      .pattern_sync_live(pattern_sync_live)
   );

   ////////////////////////////////////////////////////////////////////////////
   // latched status and pending interrupts
   logic [7:0] cond_ff, status_ff, pend_ff;
   wire logic [7:0] cond_now = {below_ff, 3'b000, sense_ff.carrier_lost,
      sense_ff.cur_limit, sense_ff.tx_open, tx_clock_lost_ff};
   wire logic [7:0] evt_now = {1'b0, timer_evt_ff, sig_evt_ff,
      jf_ff && !jf_d_ff, 4'h0};
   // conditions stay set while present so a read cannot hide a live fault
   wire logic [7:0] st_set = (cond_now & CONDITION_MASK) | evt_now;
   wire logic [7:0] pend_set = ((cond_now ^ cond_ff) & CONDITION_MASK) | evt_now;
   wire logic rd_status = cpu_req.rd && hit(OFF_STATUS_ONE);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cond_ff <= 8'h00;
         status_ff <= 8'h00;
         pend_ff <= 8'h00;
      end else begin
         cond_ff <= cond_now;
         // set wins over the read-clear in the same cycle
         status_ff <= (rd_status ? 8'h00 : status_ff) | st_set;
         pend_ff <= (rd_status ? 8'h00 : pend_ff) | pend_set;
      end
   end

   assign irq = |(pend_ff & mask_ff);

   ////////////////////////////////////////////////////////////////////////////
   // read path
   wire logic [7:0] info_rt = {pattern_sync_live, sense_ff.code_seen, sense_ff.cur_limit,
      sense_ff.tx_open, sense_ff.level};
   wire logic [7:0] rd_mux = hit(OFF_INFO_RT) ? info_rt :
      hit(OFF_STATUS_ONE) ? status_ff :
      hit(OFF_MASK_ONE) ? mask_ff :
      hit(OFF_CTRL_TWO) ? ctrl_two_ff :
      hit(OFF_CTRL_CLK_CMI) ? ctrl_cmi_ff :
      hit(OFF_SIG_ENABLE) ? sig_en_ff : 8'h00;
   logic [7:0] rdata_ff;
   logic rvalid_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= cpu_req.rd;
         if (cpu_req.rd) rdata_ff <= rd_mux;
      end
   end

   assign cpu_rdata = rdata_ff;
   assign cpu_rvalid = rvalid_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_irq_follows_pend: assert property (@(posedge sys_clk) disable iff (rst)
      (rd_status && !wr_mask && ((pend_set & mask_ff) == 8'h00)) |=> !irq)
      else $error("irq held after all pending serviced");
   a_mask_blocks: assert property (@(posedge sys_clk) disable iff (rst)
      (mask_ff == 8'h00) |-> !irq) else $error("irq with all sources masked");
   a_cond_fall_irq: assert property (@(posedge sys_clk) disable iff (rst)
      (!rd_status && cond_ff[ST_CARRIER_LOST] && !cond_now[ST_CARRIER_LOST]
      && mask_ff[ST_CARRIER_LOST]) |=> irq) else $error("falling condition missed");
   a_read_clears_trip: assert property (@(posedge sys_clk) disable iff (rst)
      (rd_status && !st_set[ST_JITTER_TRIP]) |=> !status_ff[ST_JITTER_TRIP])
      else $error("trip bit survived read");
   a_set_beats_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (rd_status && evt_now[ST_SIG_CHANGE]) |=> status_ff[ST_SIG_CHANGE])
      else $error("event lost on read");
   a_txclk_lost_time: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(tx_clock_lost_ff) |-> $past(txc_cnt_ff) == chan_limit - 7'h01)
      else $error("clock loss flagged at wrong time");
   a_txclk_edge_clears: assert property (@(posedge sys_clk) disable iff (rst)
      txc_edge |=> !tx_clock_lost_ff) else $error("clock loss held after edge");
   a_cmi_invert: assert property (@(posedge sys_clk) disable iff (rst)
      cmi_flip |=> tx_line_pos == !$past(tx_cmi_data)) else $error("cmi invert wrong");
   a_mclk_select: assert property (@(posedge sys_clk) disable iff (rst)
      (!e1_sel && !jitter_clock_source_sel && clk_prescale == 2'b11 && $stable(ctrl_cmi_ff)
      && $stable(ctrl_two_ff)) |=> mclk_expect_khz == 15'h3040)
      else $error("t1 prescale wrong");
   a_e1_mclk: assert property (@(posedge sys_clk) disable iff (rst)
      (e1_sel && clk_prescale == 2'b10 && $stable(ctrl_cmi_ff) && $stable(ctrl_two_ff))
      |=> mclk_expect_khz == 15'h2000) else $error("e1 prescale wrong");
   a_below_qualified: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(below_ff) |-> thr_cnt_ff >= 23'(THRESH_CYCLES - 1))
      else $error("threshold bit set early");
   a_read_latency: assert property (@(posedge sys_clk) disable iff (rst)
      cpu_req.rd |=> cpu_rvalid ##1 !cpu_rvalid || $past(cpu_req.rd))
      else $error("read answer timing wrong");

   c_irq_raised: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
   c_status_read: cover property (@(posedge sys_clk) disable iff (rst)
      rd_status && status_ff != 8'h00);
   c_timer_event: cover property (@(posedge sys_clk) disable iff (rst) timer_evt_ff);
   c_pattern_lock: cover property (@(posedge sys_clk) disable iff (rst)
      $rose(pattern_sync_live));
endmodule
`default_nettype wire

//--- dv/host_port_model.sv
// host processor model driving the parallel control port
`timescale 1ns/10ps
`default_nettype none
module host_port_model
   import line_if_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // control port
   output var cpu_req_t cpu_req,
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_rvalid
);
   initial cpu_req = '0;

   // released lines carry the inverse, so a stale address never decodes by luck
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cpu_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge sys_clk);
      cpu_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      cpu_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      cpu_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
      d = 8'hxx;
      for (int i = 0; i < 4; i++) begin
         if (cpu_rvalid === 1'b1) begin
            d = cpu_rdata;
            break;
         end
         @(negedge sys_clk);
      end
   endtask
endmodule
`default_nettype wire

//--- dv/line_interface_status_irq_tb.sv
// self-checking testbench for the line-interface register set
`timescale 1ns/10ps
`default_nettype none
module line_interface_status_irq_tb
   import line_if_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   cpu_req_t cpu_req;
   logic [7:0] cpu_rdata;
   logic cpu_rvalid;
   line_sense_t sense = '0;
   logic tx_clock_in = 1'b0;
   logic jfifo = 1'b0;
   logic tick = 1'b0;
   logic perr = 1'b0;
   logic [7:0] sig_state = 8'h00;
   logic tx_cmi = 1'b0;
   logic rx_line = 1'b0;
   logic txclk_run = 1'b1;
   logic fast_sel = 1'b1;
   logic tx_line_pos, rx_cmi_data, cme, pll, e1, irq;
   logic [14:0] mclk;
   int mismatches = 0;
   int comparisons = 0;

   always #50 sys_clk = ~sys_clk;

   // transmit clock toggles every 8 cycles, well inside one channel time, so loss never trips by accident
   initial forever begin
      repeat (8) @(negedge sys_clk);
      if (txclk_run) tx_clock_in = ~tx_clock_in;
   end

   host_port_model i_host (.sys_clk(sys_clk), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
      .cpu_rvalid(cpu_rvalid));

   // short counts keep the run brief
   line_interface_status_irq #(.TIMER_T1_SEC_BITS(20), .TIMER_T1_FAST_BITS(12),
      .TIMER_E1_SEC_BITS(20), .TIMER_E1_FAST_BITS(20), .THRESH_CYCLES(10)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
      .cpu_rvalid(cpu_rvalid), .sense_pins(sense), .tx_clock_in(tx_clock_in),
      .jitter_fifo_near(jfifo), .rx_bit_tick(tick), .pattern_bit_err(perr),
      .sig_state(sig_state), .count_interval_sel(fast_sel), .tx_cmi_data(tx_cmi),
      .tx_line_pos(tx_line_pos), .rx_line_pos(rx_line), .rx_cmi_data(rx_cmi_data),
      .coded_mark_enable(cme), .mclk_expect_khz(mclk), .jitter_atten_clock_pll(pll),
      .e1_mode(e1), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      check(16'(d & m), 16'(e));
   endtask

   task automatic clr();
      logic [7:0] d;
      i_host.rd(OFF_STATUS_ONE, d);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic pulse(input int n, input logic e);
      repeat (n) begin
         @(negedge sys_clk);
         tick = 1'b1;
         perr = e;
         @(negedge sys_clk);
         tick = 1'b0;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] offs [7] = '{8'h11, 8'h16, 8'h17, 8'h79, 8'h7b, 8'h40, 8'h55};
      foreach (offs[i]) rdchk(offs[i], 8'hff, 8'h00);
      i_host.wr(OFF_MASK_ONE, 8'ha5);
      rdchk(OFF_MASK_ONE, 8'hff, 8'ha5);
      i_host.wr(OFF_INFO_RT, 8'hff);
      rdchk(OFF_INFO_RT, 8'hff, 8'h00);
      i_host.wr(OFF_MASK_ONE, 8'h00);
   endtask

   task automatic t_timer();
      clr();
      i_host.wr(OFF_MASK_ONE, 8'h40);
      pulse(11, 1'b0);
      cyc(4);
      check(16'(irq), 16'h0000);
      pulse(1, 1'b0);
      cyc(3);
      check(16'(irq), 16'h0001);
      rdchk(OFF_STATUS_ONE, 8'h40, 8'h40);
      cyc(1);
      check(16'(irq), 16'h0000);
      i_host.wr(OFF_MASK_ONE, 8'h00);
      // one-second interval; errored bits keep the pattern hunter from locking
      fast_sel = 1'b0;
      pulse(19, 1'b1);
      cyc(4);
      rdchk(OFF_STATUS_ONE, 8'h40, 8'h00);
      pulse(1, 1'b1);
      cyc(4);
      rdchk(OFF_STATUS_ONE, 8'h40, 8'h40);
   endtask

   task automatic t_sync();
      pulse(1, 1'b1);
      pulse(31, 1'b0);
      cyc(4);
      rdchk(OFF_INFO_RT, 8'h80, 8'h00);
      pulse(1, 1'b0);
      cyc(4);
      rdchk(OFF_INFO_RT, 8'h80, 8'h80);
      pulse(5, 1'b1);
      cyc(4);
      rdchk(OFF_INFO_RT, 8'h80, 8'h80);
      pulse(1, 1'b1);
      cyc(4);
      rdchk(OFF_INFO_RT, 8'h80, 8'h00);
   endtask

   task automatic t_clock();
      for (int m = 0; m < 3; m++) begin
         i_host.wr(OFF_CTRL_TWO, (m == 2) ? 8'h80 : (m == 1) ? 8'h08 : 8'h00);
         for (int c = 0; c < 4; c++) begin
            i_host.wr(OFF_CTRL_CLK_CMI, {2'b00, c[1:0], 4'h0});
            cyc(3);
            check(16'(mclk), (m == 0 ? 16'h0608 : 16'h0800) << c);
            check(16'({pll, e1}), 16'({m == 1, m == 2}));
            rdchk(OFF_CTRL_CLK_CMI, 8'h30, {2'b00, c[1:0], 4'h0});
         end
      end
      i_host.wr(OFF_CTRL_TWO, 8'h00);
   endtask

   task automatic t_cmi();
      for (int k = 0; k < 4; k++) begin
         i_host.wr(OFF_CTRL_CLK_CMI, {k[1:0], 6'h00});
         for (int d = 0; d < 2; d++) begin
            tx_cmi = d[0];
            rx_line = d[0];
            cyc(4);
            check(16'({tx_line_pos, rx_cmi_data, cme}), 16'({{2{d[0] ^ (k == 3)}}, k[1]}));
         end
      end
   endtask

   task automatic t_info();
      sense = '{tx_open: 1'b1, cur_limit: 1'b1, carrier_lost: 1'b0, below_thresh: 1'b0,
         code_seen: 1'b1, level: 4'hf};
      cyc(4);
      rdchk(OFF_INFO_RT, 8'h7f, 8'h7f);
      sense = '0;
      sense.level = 4'ha;
      cyc(4);
      rdchk(OFF_INFO_RT, 8'h7f, 8'h0a);
      sense = '0;
      cyc(5);
      clr();
   endtask

   task automatic t_cond();
      i_host.wr(OFF_MASK_ONE, 8'h02);
      clr();
      sense.tx_open = 1'b1;
      cyc(5);
      check(16'(irq), 16'h0001);
      rdchk(OFF_STATUS_ONE, 8'h0f, 8'h02);
      cyc(1);
      check(16'(irq), 16'h0000);
      sense.tx_open = 1'b0;
      cyc(5);
      check(16'(irq), 16'h0001);
      i_host.wr(OFF_MASK_ONE, 8'h00);
      check(16'(irq), 16'h0000);
      clr();
      sense.cur_limit = 1'b1;
      sense.carrier_lost = 1'b1;
      cyc(5);
      rdchk(OFF_STATUS_ONE, 8'h0f, 8'h0c);
      check(16'(irq), 16'h0000);
      // pending already serviced, so unmasking alone must not raise irq
      i_host.wr(OFF_MASK_ONE, 8'h08);
      check(16'(irq), 16'h0000);
      sense = '0;
      cyc(5);
      check(16'(irq), 16'h0001);
      i_host.wr(OFF_MASK_ONE, 8'h00);
      clr();
   endtask

   task automatic t_txclk();
      clr();
      txclk_run = 1'b0;
      cyc(30);
      rdchk(OFF_STATUS_ONE, 8'h01, 8'h00);
      cyc(40);
      rdchk(OFF_STATUS_ONE, 8'h01, 8'h01);
      txclk_run = 1'b1;
      cyc(20);
      clr();
      rdchk(OFF_STATUS_ONE, 8'h01, 8'h00);
   endtask

   task automatic t_events();
      i_host.wr(OFF_SIG_ENABLE, 8'h01);
      clr();
      jfifo = 1'b1;
      cyc(5);
      rdchk(OFF_STATUS_ONE, 8'h10, 8'h10);
      rdchk(OFF_STATUS_ONE, 8'h10, 8'h00);
      jfifo = 1'b0;
      sig_state = 8'h02;
      cyc(4);
      rdchk(OFF_STATUS_ONE, 8'h20, 8'h00);
      sig_state = 8'h03;
      cyc(4);
      rdchk(OFF_STATUS_ONE, 8'h20, 8'h20);
   endtask

   task automatic t_thresh();
      sense.below_thresh = 1'b1;
      cyc(5);
      rdchk(OFF_STATUS_ONE, 8'h80, 8'h00);
      cyc(20);
      rdchk(OFF_STATUS_ONE, 8'h80, 8'h80);
      sense = '0;
   endtask

   task automatic wrap_up();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(2);
      t_regs();
      t_timer();
      t_sync();
      t_clock();
      t_cmi();
      t_info();
      t_cond();
      t_txclk();
      t_events();
      t_thresh();
      wrap_up();
   end

   // whole run is well under a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
